//--- dbtc_checker_properties.sv
`include "dbtc_defs.vh"
module dbtc_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        reset,
  // Register port
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_ff,
  // Scheduler
  input wire        act_issue,
  input wire        pre_issue,
  input wire [2:0]  cmd_bank,
  input wire [7:0]  act_permit_ff,
  input wire [7:0]  pre_permit_ff,
  // Calibration
  input wire        calib_run,
  input wire        calib_active_ff,
  input wire [2:0]  calib_bank_ff,
  input wire [12:0] calib_col_ff,
  input wire [15:0] calib_row_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] dly_ff;
  reg [31:0] cal_ff;
  reg [2:0]  bank_ff;
  // Shadows of the written registers and last activated bank
  always @(posedge ref_clk) begin
    if (reset) begin
      dly_ff <= 32'h00000000;
      cal_ff <= 32'h00000000;
    end else if (reg_wr && reg_addr == 8'h00) begin
      dly_ff <= reg_wdata & 32'h003F3F1F;
    end else if (reg_wr && reg_addr == 8'h04) begin
      cal_ff <= reg_wdata;
    end
    if (act_issue)
      bank_ff <= cmd_bank;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  dly_readback_a: assert property (reg_rd && reg_addr == 8'h00
    |=> reg_rdata_ff == dly_ff) else $error("delay config readback wrong");
  cal_readback_a: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata_ff == cal_ff) else $error("calib address readback wrong");
  act_holdoff_a: assert property (act_issue
    |=> act_permit_ff == 8'h00) else $error("permit high after activate");
  act_spacing_a: assert property (act_issue && dly_ff == 32'h00000400
    |=> !act_permit_ff[bank_ff] [*4] ##1 act_permit_ff[bank_ff])
    else $error("same bank spacing wrong");
  pre_holdoff_a: assert property (act_issue
    |=> !pre_permit_ff[$past(cmd_bank)]) else $error("precharge not held");
  zero_nowait_a: assert property (act_issue && dly_ff == 0 ##1 !act_issue
    |=> act_permit_ff == 8'hFF) else $error("zero setting added a wait");
  calib_start_a: assert property ($rose(calib_run)
    |-> ##[2:6] calib_active_ff) else $error("calibration not active");
  calib_bank_a: assert property (calib_active_ff && $past(calib_active_ff)
    |-> calib_bank_ff == cal_ff[31:29]) else $error("calib bank wrong");
  calib_col_a: assert property (calib_active_ff && $past(calib_active_ff)
    |-> calib_col_ff == cal_ff[28:16]) else $error("calib column wrong");
  calib_row_a: assert property (calib_active_ff && $past(calib_active_ff)
    |-> calib_row_ff == cal_ff[15:0]) else $error("calib row wrong");
  // Main scenarios
  act_seen_c: cover property (act_issue);
  pre_seen_c: cover property (pre_issue);
  calib_seen_c: cover property ($rose(calib_active_ff));
endmodule
bind dbtc_top dbtc_checker chk_u (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .act_issue(act_issue),
  .pre_issue(pre_issue), .cmd_bank(cmd_bank), .calib_run(calib_run),
  .act_permit_ff(act_permit_ff), .pre_permit_ff(pre_permit_ff),
  .calib_active_ff(calib_active_ff), .calib_bank_ff(calib_bank_ff),
  .calib_col_ff(calib_col_ff), .calib_row_ff(calib_row_ff));

//--- dbtc_defs.vh
`ifndef DBTC_DEFS_VH
`define DBTC_DEFS_VH
// Register offsets
`define DBTC_ADDR_W        8
`define DBTC_OFF_DLYCFG3   8'h00
`define DBTC_OFF_CALADR    8'h04
`define DBTC_OFF_STATUS    8'h08
// Delay configuration three fields
`define DBTC_FAW_HI        21
`define DBTC_FAW_LO        16
`define DBTC_RRSB_HI       13
`define DBTC_RRSB_LO       8
`define DBTC_RAS2PC_HI     4
`define DBTC_RAS2PC_LO     0
`define DBTC_DLYCFG3_MASK  32'h003F3F1F
// Calibration address fields
`define DBTC_CBANK_HI      31
`define DBTC_CBANK_LO      29
`define DBTC_CCOL_HI       28
`define DBTC_CCOL_LO       16
`define DBTC_CROW_HI       15
`define DBTC_CROW_LO       0
// Reset values
`define DBTC_DLYCFG3_RST   32'h00000000
`define DBTC_CALADR_RST    32'h00000000
// Geometry
`define DBTC_NBANK         8
`define DBTC_CNT_W         6
`endif

//--- dbtc_down_cnt.v
`include "dbtc_defs.vh"
module dbtc_down_cnt (
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   reset,
  // Control
  input  wire                   load,
  input  wire [`DBTC_CNT_W-1:0] load_val,
  // Status
  output wire                   busy
);
  reg  [`DBTC_CNT_W-1:0] cnt_ff;
  reg  [`DBTC_CNT_W-1:0] nxt_cnt;

  // Load wins, else count down to zero
  always @* begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != 6'h00) begin
      nxt_cnt = cnt_ff - 6'h01;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 6'h00);
endmodule

//--- dbtc_mem_model.sv
module dbtc_mem_model (
  // Clock
  input  wire       ref_clk,
  // Commands from the controller
  input  wire       act_issue,
  input  wire       pre_issue,
  input  wire [2:0] cmd_bank,
  // Banks held open
  output reg  [7:0] open_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  initial open_ff = 8'h00;
  // Open on activate, close on precharge
  always @(posedge ref_clk) begin
    if (act_issue)
      open_ff[cmd_bank] <= 1'h1;
    if (pre_issue)
      open_ff[cmd_bank] <= 1'h0;
  end
endmodule

//--- dbtc_sync.v
module dbtc_sync (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset,
  // Asynchronous input and filtered level
  input  wire async_in,
  output reg  level_ff
);
  reg  meta_ff;
  reg  s2_ff;
  reg  s3_ff;

  // Three stages; level moves when stages two and three agree
  always @(posedge ref_clk) begin
    if (reset) begin
      meta_ff  <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end
endmodule

//--- dbtc_top.v
// Overview of operation
// - At most four activates in any window of four_activate_window_cycles clocks.
// - Same-bank activates spaced by at least same_bank_activate_spacing clocks.
// - Precharge waits activate_to_precharge_cycles clocks after that bank's activate.
// - Calibration drives bank address from calib_bank_addr, bits 31 to 29.
// - Calibration column comes from calib_column_addr, bits 28 to 16.
// - Calibration row comes from calib_row_addr, bits 15 to 0.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`include "dbtc_defs.vh"
module dbtc_top (
  // Clock and reset
  input  wire                    ref_clk,
  input  wire                    reset,
  // Register port
  input  wire [`DBTC_ADDR_W-1:0] reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata_ff,
  // Scheduler issue
  input  wire                    act_issue,
  input  wire                    pre_issue,
  input  wire [2:0]              cmd_bank,
  // Scheduler permits, per bank
  output reg  [7:0]              act_permit_ff,
  output reg  [7:0]              pre_permit_ff,
  // Calibration request, from the calibration engine's clock
  input  wire                    calib_run,
  // Calibration address to memory
  output reg                     calib_active_ff,
  output reg  [2:0]              calib_bank_ff,
  output reg  [12:0]             calib_col_ff,
  output reg  [15:0]             calib_row_ff
);
  // Register map
  //   0x00 delay configuration three, unused bits read zero
  //   0x04 calibration address, all 32 bits kept
  //   0x08 status, violation bits are write one to clear
  //   other addresses read zero and ignore writes
  //
  // Status word
  //   bit 0      activate issued while its permit was low
  //   bit 1      precharge issued while its permit was low
  //   bits 9:2   current precharge permits, one per bank
  //   bit 10     every activate permit low
  //   bit 11     calibration active
  //   bits 31:12 zero
  //
  // Read timing
  //   read data stand only in the cycle after the read strobe
  //   and are zero in every other cycle
  //   no wait states; back to back strobes are taken
  //
  // Permit timing
  //   permits are registered, so the scheduler sees them
  //   one clock after the counters move
  //   every activate drops all activate permits for a cycle
  //   this keeps two activates from landing on adjacent edges
  //   while the counters are still loading
  //   the registered permit makes nonzero bank spacings one clock
  //   longer than programmed and the window two; safe, never shorter
  //
  // Four-activate window
  //   the ages of the last four activates are kept
  //   a new activate enters at age zero and pushes the rest
  //   ages saturate at the top so that old entries never
  //   wrap back into the window
  //   the window is full while the oldest of four is younger
  //   than the programmed window length
  //   a zero window length never fills the window
  //
  // Same-bank and activate-to-precharge spacing
  //   each bank has two down counters loaded on its activate
  //   a counter that is not zero holds that bank's permit low
  //   the load value is trimmed by one for the issue cycle
  //   a zero setting loads zero and adds no wait
  //   the precharge permit of the activated bank also drops
  //   in the issue cycle, so a precharge never follows
  //   its activate on the very next edge
  //
  // Violations
  //   an issue against a low permit is not blocked here;
  //   the scheduler owns the command, this block only records
  //   the flags are sticky until software clears them
  //   a violation in the clearing cycle keeps the flag set
  //
  // Calibration
  //   the run request comes from another clock domain
  //   it passes three flops and counts once two agree
  //   the address outputs load while the request stands
  //   and hold their last value once it drops
  //   writing the calibration address during a run moves the
  //   outputs one clock after the register changes
  //
  // Limitations
  //   the window length is at most 63 clocks
  //   the same-bank spacing is at most 63 clocks
  //   the activate-to-precharge spacing is at most 31 clocks
  //   counts change only on register writes; a write while
  //   a counter runs affects the next activate only
  //   a bank number is taken from the shared command bank
  //   input, so activate and precharge in one cycle must
  //   target the same bank
  //
  // Reset
  //   all registers clear; permits stay low during reset
  //   and open one clock after its release
  //   the read port answers from the first edge after release
  //
  // Outputs
  //   every output is a flop; no combinational path runs
  //   from an input to an output of this block
  //
  // Resources
  //   sixteen six-bit down counters, four six-bit ages,
  //   two 32-bit registers and a four-flop synchroniser
  //

  // Registers
  reg  [31:0] dlycfg3_ff;
  reg  [31:0] caladr_ff;
  reg  [1:0]  wr_err_ff;
  reg  [31:0] nxt_rdata;

  wire [5:0]  four_activate_window_cycles;
  wire [5:0]  same_bank_activate_spacing;
  wire [4:0]  activate_to_precharge_cycles;
  wire [2:0]  calib_bank_addr;
  wire [12:0] calib_column_addr;
  wire [15:0] calib_row_addr;
  wire        calib_lvl;

  assign four_activate_window_cycles  =
    dlycfg3_ff[`DBTC_FAW_HI:`DBTC_FAW_LO];
  assign same_bank_activate_spacing   =
    dlycfg3_ff[`DBTC_RRSB_HI:`DBTC_RRSB_LO];
  assign activate_to_precharge_cycles =
    dlycfg3_ff[`DBTC_RAS2PC_HI:`DBTC_RAS2PC_LO];
  assign calib_bank_addr   = caladr_ff[`DBTC_CBANK_HI:`DBTC_CBANK_LO];
  assign calib_column_addr = caladr_ff[`DBTC_CCOL_HI:`DBTC_CCOL_LO];
  assign calib_row_addr    = caladr_ff[`DBTC_CROW_HI:`DBTC_CROW_LO];

  // Issued commands that broke a permit, seen by status
  wire act_bad;
  wire pre_bad;

  // Register writes and sticky violation flags
  always @(posedge ref_clk) begin
    if (reset) begin
      dlycfg3_ff <= `DBTC_DLYCFG3_RST;
      caladr_ff  <= `DBTC_CALADR_RST;
      wr_err_ff  <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `DBTC_OFF_DLYCFG3) begin
        dlycfg3_ff <= reg_wdata & `DBTC_DLYCFG3_MASK;
      end
      if (reg_wr && reg_addr == `DBTC_OFF_CALADR) begin
        caladr_ff <= reg_wdata;
      end
      // Write one clears; a new event wins over the clear
      if (reg_wr && reg_addr == `DBTC_OFF_STATUS) begin
        wr_err_ff <= (wr_err_ff & ~reg_wdata[1:0]) | {pre_bad, act_bad};
      end else begin
        wr_err_ff <= wr_err_ff | {pre_bad, act_bad};
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `DBTC_OFF_DLYCFG3: nxt_rdata = dlycfg3_ff;
      `DBTC_OFF_CALADR:  nxt_rdata = caladr_ff;
      `DBTC_OFF_STATUS:  nxt_rdata = {20'h00000, calib_active_ff,
                                      act_permit_ff == 8'h00,
                                      pre_permit_ff, wr_err_ff};
      default:           nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 32'h00000000;
    end
  end

  // Four-activate window: age of the last four activates
  reg  [5:0] age_ff [0:3];
  reg  [3:0] age_vld_ff;
  integer    k;
  wire       win_full;

  // Oldest of four entries still inside the window blocks a fifth
  assign win_full = (age_vld_ff == 4'hF) &&
                    (age_ff[3] < four_activate_window_cycles);

  always @(posedge ref_clk) begin
    if (reset) begin
      age_vld_ff <= 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
        age_ff[k] <= 6'h00;
      end
    end else begin
      // Age every entry, saturating, retire past the window
      for (k = 0; k < 4; k = k + 1) begin
        if (age_ff[k] != 6'h3F) begin
          age_ff[k] <= age_ff[k] + 6'h01;
        end
      end
      if (act_issue) begin
        // Shift in a new activate at age zero
        age_ff[0]  <= 6'h00;
        // Saturate while shifting so old entries never wrap
        age_ff[1]  <= (age_ff[0] == 6'h3F) ? 6'h3F
                      : age_ff[0] + 6'h01;
        age_ff[2]  <= (age_ff[1] == 6'h3F) ? 6'h3F
                      : age_ff[1] + 6'h01;
        age_ff[3]  <= (age_ff[2] == 6'h3F) ? 6'h3F
                      : age_ff[2] + 6'h01;
        age_vld_ff <= {age_vld_ff[2:0], 1'b1};
      end
    end
  end

  // Per-bank spacing counters
  wire [7:0] rr_busy;
  wire [7:0] rp_busy;
  wire [7:0] bank_hit;

  genvar b;
  generate
    for (b = 0; b < `DBTC_NBANK; b = b + 1) begin : g_bank
      localparam [2:0] BANK_ID = b;
      assign bank_hit[b] = act_issue && (cmd_bank == BANK_ID);
      // Load value minus one counts the issue cycle itself
      dbtc_down_cnt u_rr (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .load     (bank_hit[b]),
        .load_val (same_bank_activate_spacing -
                   ((same_bank_activate_spacing != 6'h00) ? 6'h01
                                                          : 6'h00)),
        .busy     (rr_busy[b])
      );
      dbtc_down_cnt u_rp (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .load     (bank_hit[b]),
        .load_val ({1'b0, activate_to_precharge_cycles} -
                   ((activate_to_precharge_cycles != 5'h00) ? 6'h01
                                                            : 6'h00)),
        .busy     (rp_busy[b])
      );
    end
  endgenerate

  // Issuing against a withdrawn permit is flagged
  assign act_bad = act_issue && !act_permit_ff[cmd_bank];
  assign pre_bad = pre_issue && !pre_permit_ff[cmd_bank];

  // Permits, registered; hold off in the issue cycle itself
  always @(posedge ref_clk) begin
    if (reset) begin
      act_permit_ff <= 8'h00;
      pre_permit_ff <= 8'h00;
    end else begin
      act_permit_ff <= (win_full || act_issue) ? 8'h00
                       : ~rr_busy;
      pre_permit_ff <= ~rp_busy & ~bank_hit;
    end
  end

  // Calibration request crosses in through three flops
  dbtc_sync u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (calib_run),
    .level_ff (calib_lvl)
  );

  // Calibration address presented while calibration runs
  always @(posedge ref_clk) begin
    if (reset) begin
      calib_active_ff <= 1'b0;
      calib_bank_ff   <= 3'h0;
      calib_col_ff    <= 13'h0000;
      calib_row_ff    <= 16'h0000;
    end else begin
      calib_active_ff <= calib_lvl;
      if (calib_lvl) begin
        calib_bank_ff <= calib_bank_addr;
        calib_col_ff  <= calib_column_addr;
        calib_row_ff  <= calib_row_addr;
      end
    end
  end
endmodule

//--- testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         ref_clk = 1'h0, reset = 1'h1, link_clk = 1'h0;
  reg         reg_wr = 1'h0, reg_rd = 1'h0, calib_run = 1'h0;
  reg         act_issue = 1'h0, pre_issue = 1'h0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h00000000;
  reg  [2:0]  cmd_bank = 3'h0;
  wire [31:0] rdata;
  wire [7:0]  actp, prep, open_banks;
  wire        cal_act;
  wire [2:0]  cbank;
  wire [12:0] ccol;
  wire [15:0] crow;
  int         bad_count = 0, samples_checked = 0, i, k;
  // Clocks
  always #5 ref_clk = ~ref_clk;
  always #40 link_clk = ~link_clk;
  dbtc_top dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(rdata), .act_issue(act_issue), .pre_issue(pre_issue),
    .cmd_bank(cmd_bank), .act_permit_ff(actp), .pre_permit_ff(prep),
    .calib_run(calib_run), .calib_active_ff(cal_act),
    .calib_bank_ff(cbank), .calib_col_ff(ccol), .calib_row_ff(crow));
  dbtc_mem_model mem_u (.ref_clk(ref_clk), .act_issue(act_issue),
    .pre_issue(pre_issue), .cmd_bank(cmd_bank), .open_ff(open_banks));
  task final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stands in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata_ff", e, rdata & m);
  endtask
  // Command held for n cycles
  task cmd(input p, input [2:0] b, input int n);
    @(posedge ref_clk);
    act_issue <= !p;
    pre_issue <= p;
    cmd_bank <= b;
    repeat (n) @(posedge ref_clk);
    act_issue <= 1'h0;
    pre_issue <= 1'h0;
  endtask
  // Permit low until cycle w after the issue, high at w
  task hold(input p, input [2:0] b, input int w);
    for (i = 1; i <= w; i++) begin
      #1 chk("permit", i == w, p ? prep[b] : actp[b]);
      @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    rd(8'h00, 32'h00000000, 32'hFFFFFFFF);
    rd(8'h04, 32'h00000000, 32'hFFFFFFFF);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h003F3F1F, 32'hFFFFFFFF);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'h00000000, 32'hFFFFFFFF);
    wr(8'h00, 32'h00000000);
    cmd(1'h0, 3'h1, 1);
    hold(1'h0, 3'h1, 2);
    cmd(1'h0, 3'h2, 2);
    rd(8'h08, 32'h00000001, 32'h00000001);
    wr(8'h08, 32'h00000001);
    rd(8'h08, 32'h00000000, 32'h00000001);
    wr(8'h00, 32'h00000400);
    cmd(1'h0, 3'h3, 1);
    hold(1'h0, 3'h3, 5);
    wr(8'h00, 32'h00000005);
    cmd(1'h0, 3'h1, 1);
    hold(1'h1, 3'h1, 6);
    #1 chk("open_ff", 32'h1, open_banks[1]);
    cmd(1'h1, 3'h1, 1);
    #1 chk("open_ff", 32'h0, open_banks[1]);
    wr(8'h00, 32'h00140000);
    for (k = 0; k < 4; k++)
      cmd(1'h0, k[2:0], 1);
    repeat (11) @(posedge ref_clk);
    #1 chk("act_permit_ff", 32'h00000000, actp);
    repeat (4) @(posedge ref_clk);
    #1 chk("act_permit_ff", 32'h000000FF, actp);
    wr(8'h04, 32'hB5A5C3D2);
    @(posedge link_clk) calib_run <= 1'h1;
    repeat (8) @(posedge ref_clk);
    #1 chk("calib_bank_ff", 32'h5, cbank);
    chk("calib_active_ff", 32'h1, cal_act);
    chk("calib_col_ff", 32'h15A5, ccol);
    chk("calib_row_ff", 32'hC3D2, crow);
    @(posedge link_clk) calib_run <= 1'h0;
    repeat (8) @(posedge ref_clk);
    wr(8'h04, 32'h00000000);
    repeat (8) @(posedge ref_clk);
    #1 chk("calib_row_ff", 32'hC3D2, crow);
    final_report;
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    final_report;
  end
endmodule
